/* inc/fcs_pkg.sv */
// Package for the flash command sequencer: constants, states and carriers
// What this block does
// - Commands arrive as 16-bit writes at even addresses; only low byte decoded.
// - Low byte FF selects array reads until command 70 or the start of an automatic operation.
// - After command 70 the next even-address read returns the status byte.
// - Command 50 clears both the erase-error and program-error flags.
// - Program: 41, lower word, upper word; then automatic program and verify.
// - Block erase: 20, then D0 at block top address; erase and verify.
// - Blank check: 25, then D0; non-blank sets the erase-error flag.
// - Ready reads 0 while program, erase or blank check runs, else 1.
// - Starting any automatic operation switches reads to status mode.
// - Status byte: bit 7 ready, bit 5 erase error, bit 4 program error.
// - Program, erase and blank check are refused while any error flag is set.
// - Interrupt resets the control register and aborts any running operation.
// - Low byte FF in an erase-type second cycle aborts to array mode.
// - Commands are ignored while the command enable bit is 0.
package fcs_pkg;

  // Array geometry: word index width and words per block (as a bit width)
  localparam int AW    = 8;
  localparam int BLK_W = 6;
  localparam int BYTE_AW = AW + 1;

  // Command codes in the low data byte
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h41;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLANK_CHECK  = 8'h25;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;

  // Status byte layout
  localparam int STAT_READY_POS   = 7;
  localparam int STAT_ERASE_POS   = 5;
  localparam int STAT_PROGRAM_POS = 4;

  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Programming time of one 4-byte unit, rounded up to whole clocks
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 4000;
  localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  typedef enum logic [2:0] {
    FCS_IDLE, FCS_PRG2, FCS_PRG3, FCS_ERS2, FCS_BLK2,
    FCS_PROG_RUN, FCS_ERASE_RUN, FCS_BLANK_RUN
  } fcs_seq_t;

  // One flash bus cycle from the CPU
  typedef struct packed {
    logic               we;
    logic [BYTE_AW-1:0] addr;
    logic [15:0]        wdata;
  } fcs_bus_t;

  // Whole sequencer state
  typedef struct packed {
    fcs_seq_t         seq;
    logic             status_mode;
    logic             cmd_en;
    logic             en_armed;
    logic             ready;
    logic             erase_err;
    logic             prog_err;
    logic [AW-1:0]    waddr_lo;
    logic [AW-1:0]    waddr_hi;
    logic [15:0]      data_lo;
    logic [15:0]      data_hi;
    logic [CNT_W-1:0] cnt;
    logic [15:0]      rdata;
    logic             rvalid;
    logic [1:0]       irq_sync;
  } fcs_state_t;

  localparam fcs_state_t STATE_RESET = '{
    seq: FCS_IDLE, status_mode: 1'b0, cmd_en: 1'b0, en_armed: 1'b0, ready: 1'b1,
    erase_err: 1'b0, prog_err: 1'b0, waddr_lo: '0, waddr_hi: '0, data_lo: '0,
    data_hi: '0, cnt: '0, rdata: '0, rvalid: 1'b0, irq_sync: '0};

endpackage

/* verilog/fcs_sequencer.sv */
// Flash command sequencer with its array, status byte and enable sequence
module fcs_sequencer (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             bus_valid_i,
  input  wire fcs_pkg::fcs_bus_t bus_i,
  input  wire logic             ctrl_we_i,
  input  wire logic             ctrl_wdata_i,
  input  wire logic             irq_i,
  output logic [15:0]           rdata_o,
  output logic                  rvalid_o,
  output logic                  ready_o,
  output logic                  erase_err_o,
  output logic                  prog_err_o,
  output logic                  cmd_en_o
);

  fcs_pkg::fcs_state_t s;
  fcs_pkg::fcs_state_t next_s;

  // Flash array, no reset: contents persist like real cells
  logic [15:0] mem [2**fcs_pkg::AW];

  logic                  mem_we;
  logic [fcs_pkg::AW-1:0] mem_wa;
  logic [15:0]           mem_wd;
  logic [fcs_pkg::AW-1:0] wa;
  logic [fcs_pkg::AW-1:0] walk_a;
  logic [7:0]            code;
  logic [7:0]            stat;
  logic                  errs;
  logic                  bus_wr;
  logic                  walk_last;
  logic                  irq_hit;
  logic                  running;

  // Bus decode helpers
  assign wa        = bus_i.addr[fcs_pkg::BYTE_AW-1:1];
  assign code      = bus_i.wdata[7:0];
  assign errs      = s.erase_err | s.prog_err;
  assign bus_wr    = bus_valid_i & bus_i.we & ~bus_i.addr[0];
  assign walk_a    = {s.waddr_lo[fcs_pkg::AW-1:fcs_pkg::BLK_W], s.cnt[fcs_pkg::BLK_W-1:0]};
  assign walk_last = &s.cnt[fcs_pkg::BLK_W-1:0];
  assign irq_hit   = s.irq_sync[1];
  assign running   = (s.seq == fcs_pkg::FCS_PROG_RUN) || (s.seq == fcs_pkg::FCS_ERASE_RUN) ||
                     (s.seq == fcs_pkg::FCS_BLANK_RUN);

  // Status byte assembly
  always_comb begin
    stat = 8'h00;
    stat[fcs_pkg::STAT_READY_POS]   = s.ready;
    stat[fcs_pkg::STAT_ERASE_POS]   = s.erase_err;
    stat[fcs_pkg::STAT_PROGRAM_POS] = s.prog_err;
  end

  // Next-state logic of the whole sequencer
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.irq_sync = {s.irq_sync[0], irq_i};
    mem_we = 1'b0;
    mem_wa = walk_a;
    mem_wd = fcs_pkg::ERASED_WORD;

    // Any flash access between the two writes breaks the 0-then-1 enable sequence
    if (bus_valid_i) begin
      next_s.en_armed = 1'b0;
    end
    if (ctrl_we_i) begin
      if (!ctrl_wdata_i) begin
        next_s.cmd_en   = 1'b0;
        next_s.en_armed = 1'b1;
      end else if (s.en_armed) begin
        next_s.cmd_en   = 1'b1;
        next_s.en_armed = 1'b0;
      end
    end

    // Reads: status byte at even addresses in status mode, array word otherwise
    if (bus_valid_i && !bus_i.we) begin
      next_s.rvalid = 1'b1;
      if (s.status_mode && !bus_i.addr[0]) begin
        next_s.rdata = {8'h00, stat};
      end else begin
        next_s.rdata = mem[wa];
      end
    end

    unique case (s.seq)
      fcs_pkg::FCS_IDLE: begin
        if (bus_wr && s.cmd_en) begin
          unique case (code)
            fcs_pkg::CMD_READ_ARRAY:   next_s.status_mode = 1'b0;
            fcs_pkg::CMD_READ_STATUS:  next_s.status_mode = 1'b1;
            fcs_pkg::CMD_CLEAR_STATUS: begin
              next_s.erase_err = 1'b0;
              next_s.prog_err  = 1'b0;
            end
            fcs_pkg::CMD_PROGRAM:      if (!errs) next_s.seq = fcs_pkg::FCS_PRG2;
            fcs_pkg::CMD_BLOCK_ERASE:  if (!errs) next_s.seq = fcs_pkg::FCS_ERS2;
            fcs_pkg::CMD_BLANK_CHECK:  if (!errs) next_s.seq = fcs_pkg::FCS_BLK2;
            default: ;
          endcase
        end
      end
      fcs_pkg::FCS_PRG2: begin
        if (bus_wr && s.cmd_en) begin
          next_s.waddr_lo = wa;
          next_s.data_lo  = bus_i.wdata;
          next_s.seq      = fcs_pkg::FCS_PRG3;
        end
      end
      fcs_pkg::FCS_PRG3: begin
        if (bus_wr && s.cmd_en) begin
          next_s.waddr_hi    = wa;
          next_s.data_hi     = bus_i.wdata;
          next_s.cnt         = '0;
          next_s.ready       = 1'b0;
          next_s.status_mode = 1'b1;
          next_s.seq         = fcs_pkg::FCS_PROG_RUN;
        end
      end
      fcs_pkg::FCS_ERS2, fcs_pkg::FCS_BLK2: begin
        if (bus_wr && s.cmd_en) begin
          if (code == fcs_pkg::CMD_CONFIRM) begin
            next_s.waddr_lo    = wa;
            next_s.cnt         = '0;
            next_s.ready       = 1'b0;
            next_s.status_mode = 1'b1;
            next_s.seq = (s.seq == fcs_pkg::FCS_ERS2) ? fcs_pkg::FCS_ERASE_RUN
                                                      : fcs_pkg::FCS_BLANK_RUN;
          end else if (code == fcs_pkg::CMD_READ_ARRAY) begin
            next_s.status_mode = 1'b0;
            next_s.seq         = fcs_pkg::FCS_IDLE;
          end else begin
            // Bad second cycle flags a sequence error
            next_s.erase_err = 1'b1;
            next_s.prog_err  = 1'b1;
            next_s.seq       = fcs_pkg::FCS_IDLE;
          end
        end
      end
      fcs_pkg::FCS_PROG_RUN: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == '0 && (mem[s.waddr_lo] != fcs_pkg::ERASED_WORD ||
                            mem[s.waddr_hi] != fcs_pkg::ERASED_WORD)) begin
          // Cells not erased: verify can never pass
          next_s.prog_err = 1'b1;
          next_s.ready    = 1'b1;
          next_s.seq      = fcs_pkg::FCS_IDLE;
        end else if (s.cnt == fcs_pkg::CNT_W'(fcs_pkg::PROG_CYC - 2)) begin
          mem_we = 1'b1;
          mem_wa = s.waddr_lo;
          mem_wd = s.data_lo;
        end else if (s.cnt == fcs_pkg::CNT_W'(fcs_pkg::PROG_CYC - 1)) begin
          mem_we = 1'b1;
          mem_wa = s.waddr_hi;
          mem_wd = s.data_hi;
          next_s.ready = 1'b1;
          next_s.seq   = fcs_pkg::FCS_IDLE;
        end
      end
      fcs_pkg::FCS_ERASE_RUN: begin
        mem_we     = 1'b1;
        next_s.cnt = s.cnt + 1'b1;
        if (walk_last) begin
          next_s.cnt = '0;
          next_s.seq = fcs_pkg::FCS_BLANK_RUN;
        end
      end
      fcs_pkg::FCS_BLANK_RUN: begin
        next_s.cnt = s.cnt + 1'b1;
        if (mem[walk_a] != fcs_pkg::ERASED_WORD) begin
          next_s.erase_err = 1'b1;
        end
        if (walk_last) begin
          next_s.ready = 1'b1;
          next_s.seq   = fcs_pkg::FCS_IDLE;
        end
      end
    endcase

    if (irq_hit) begin
      mem_we          = 1'b0;
      next_s.cmd_en   = 1'b0;
      next_s.en_armed = 1'b0;
      next_s.ready    = 1'b1;
      next_s.seq      = fcs_pkg::FCS_IDLE;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= fcs_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Array write port
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs straight from state flops
  assign rdata_o     = s.rdata;
  assign rvalid_o    = s.rvalid;
  assign ready_o     = s.ready;
  assign erase_err_o = s.erase_err;
  assign prog_err_o  = s.prog_err;
  assign cmd_en_o    = s.cmd_en;

  // Checks on the sequencer
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Helper views for the checks below
  logic        idle_cmd;
  logic        blank_miss;
  logic [15:0] array_word;
  assign idle_cmd   = bus_wr && s.cmd_en && (s.seq == fcs_pkg::FCS_IDLE) && !irq_hit;
  // Blank walk meets a word that is not erased
  assign blank_miss = (s.seq == fcs_pkg::FCS_BLANK_RUN) &&
                      (mem[walk_a] != fcs_pkg::ERASED_WORD);
  // Array word that a read at this address would return
  assign array_word = mem[wa];

  // Ready level and mode selection
  a_ready_busy: assert property (s.ready == !running)
    else $error("ready flag disagrees with running state");
  a_status_cmd: assert property (
    idle_cmd && code == fcs_pkg::CMD_READ_STATUS |=> s.status_mode)
    else $error("status command did not select status mode");

  // Read answers in both modes and the read array command
  a_status_read: assert property (
    bus_valid_i && !bus_i.we && !bus_i.addr[0] && s.status_mode
    |=> rvalid_o && rdata_o == {8'h00, $past(stat)})
    else $error("status read returned wrong byte");
  a_word_read: assert property (
    bus_valid_i && !bus_i.we && (!s.status_mode || bus_i.addr[0])
    |=> rvalid_o && rdata_o == $past(array_word))
    else $error("array read returned wrong word");
  a_array_cmd: assert property (
    idle_cmd && code == fcs_pkg::CMD_READ_ARRAY |=> !s.status_mode)
    else $error("read array command ignored");

  // Error flags, refused commands, status mode at start and aborts
  a_clear_errs: assert property (
    idle_cmd && code == fcs_pkg::CMD_CLEAR_STATUS |=> !erase_err_o && !prog_err_o)
    else $error("clear status left an error flag");
  a_refuse_err: assert property (
    idle_cmd && errs && (code == fcs_pkg::CMD_PROGRAM || code == fcs_pkg::CMD_BLOCK_ERASE ||
    code == fcs_pkg::CMD_BLANK_CHECK) |=> s.seq == fcs_pkg::FCS_IDLE)
    else $error("operation accepted with error set");
  a_start_stat: assert property ($fell(ready_o) |-> s.status_mode)
    else $error("operation started without status mode");
  a_irq_abort: assert property (
    irq_hit |=> s.seq == fcs_pkg::FCS_IDLE && !cmd_en_o && ready_o)
    else $error("interrupt did not abort the sequencer");
  a_locked_out: assert property (
    bus_wr && !s.cmd_en && s.seq == fcs_pkg::FCS_IDLE |=> s.seq == fcs_pkg::FCS_IDLE)
    else $error("command taken while disabled");
  a_erase_ff: assert property (
    bus_wr && s.cmd_en && s.seq == fcs_pkg::FCS_ERS2 && !irq_hit &&
    code == fcs_pkg::CMD_READ_ARRAY |=> s.seq == fcs_pkg::FCS_IDLE && !s.status_mode)
    else $error("FF in second cycle did not abort");
  a_blank_flag: assert property (
    blank_miss && !irq_hit |=> erase_err_o)
    else $error("non-blank word left erase error clear");

  // Busy time: cells that are not erased end at once with a program error
  a_prog_time: assert property (
    s.seq == fcs_pkg::FCS_PRG3 && bus_wr && s.cmd_en && !irq_hit
    |=> !ready_o ##1 (prog_err_o || !ready_o) [*7])
    else $error("program finished too early");

  // Enable bit only follows an armed zero write
  a_enable_set: assert property (
    ctrl_we_i && ctrl_wdata_i && s.en_armed && !irq_hit |=> cmd_en_o)
    else $error("armed enable write did not set the bit");
  a_enable_hold: assert property (
    ctrl_we_i && ctrl_wdata_i && !s.en_armed && !irq_hit |=> cmd_en_o == $past(cmd_en_o))
    else $error("unarmed enable write changed the bit");

  // Main scenarios reached
  c_program: cover property (s.seq == fcs_pkg::FCS_PROG_RUN ##1 s.seq == fcs_pkg::FCS_IDLE);
  c_erase: cover property (s.seq == fcs_pkg::FCS_ERASE_RUN ##1 s.seq == fcs_pkg::FCS_BLANK_RUN);
  c_blank_err: cover property ($rose(erase_err_o) && s.seq == fcs_pkg::FCS_IDLE);
  c_irq_abort: cover property (irq_hit && running);
  c_prog_err: cover property ($rose(prog_err_o) && ready_o);

endmodule

/* tb/fcs_cpu_model.sv */
// CPU-side model that issues flash bus cycles and enable-bit writes
module fcs_cpu_model (
  input  wire logic         clock_i,
  output logic              bus_valid_o,
  output fcs_pkg::fcs_bus_t bus_o,
  output logic              ctrl_we_o,
  output logic              ctrl_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet bus at time zero
  initial begin
    bus_valid_o = 1'b0;
    bus_o = '0;
    ctrl_we_o = 1'b0;
    ctrl_wdata_o = 1'b0;
  end

  // One 16-bit cycle at an even address, held for one taking edge
  task automatic cycle(input logic we, input logic [8:0] addr, input logic [15:0] data);
    @(posedge clock_i);
    bus_valid_o <= 1'b1;
    bus_o <= '{we: we, addr: addr, wdata: data};
    @(posedge clock_i);
    bus_valid_o <= 1'b0;
    // Released bus shows the inverse so stale values never pass as fresh
    bus_o <= fcs_pkg::fcs_bus_t'(~{we, addr, data});
  endtask

  task automatic ctrl(input logic v);
    @(posedge clock_i);
    ctrl_we_o <= 1'b1;
    ctrl_wdata_o <= v;
    @(posedge clock_i);
    ctrl_we_o <= 1'b0;
  endtask

  // Zero then one with no bus cycle between
  task automatic enable();
    ctrl(1'b0);
    ctrl(1'b1);
  endtask

  task automatic standby();
    ctrl(1'b0);
  endtask

  // Code and lower word at one address, then upper word
  task automatic program_unit(input logic [8:0] a, input logic [7:0] up, input logic [31:0] d);
    cycle(1'b1, a, {up, fcs_pkg::CMD_PROGRAM});
    cycle(1'b1, a, d[15:0]);
    cycle(1'b1, a + 9'h002, d[31:16]);
  endtask
endmodule

/* tb/flash_command_sequencer_tb.sv */
// Self-checking bench for the flash command sequencer
module flash_command_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clock_i;
  logic              nrst_i;
  logic              irq_i;
  logic              bus_valid;
  logic              ctrl_we;
  logic              ctrl_wdata;
  fcs_pkg::fcs_bus_t bus;
  logic [15:0]       rdata;
  logic              rvalid;
  logic              ready;
  logic              erase_err;
  logic              prog_err;
  logic              cmd_en;
  logic [15:0]       exp_q[$];
  logic [31:0]       word;
  int                bad_count;
  int                samples_checked;
  int                tries;
  localparam logic [8:0] BA0 = 9'h07e;

  fcs_sequencer i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .bus_valid_i(bus_valid),
    .bus_i(bus), .ctrl_we_i(ctrl_we), .ctrl_wdata_i(ctrl_wdata), .irq_i(irq_i),
    .rdata_o(rdata), .rvalid_o(rvalid), .ready_o(ready), .erase_err_o(erase_err),
    .prog_err_o(prog_err), .cmd_en_o(cmd_en));

  fcs_cpu_model i_cpu (.clock_i(clock_i), .bus_valid_o(bus_valid), .bus_o(bus),
    .ctrl_we_o(ctrl_we), .ctrl_wdata_o(ctrl_wdata));

  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask

  // Random multiple-of-four byte address
  function automatic logic [8:0] ra();
    return 9'($urandom) & 9'h1fc;
  endfunction

  task automatic cmd(input logic [8:0] a, input logic [7:0] code);
    i_cpu.cycle(1'b1, a, {8'($urandom), code});
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_cpu.cycle(1'b0, a, 16'($urandom));
  endtask

  // Bounded wait for the ready level
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      @(negedge clock_i);
      n++;
      if (n > 400) begin
        bad_count++;
        final_report();
      end
    end
  endtask

  // Busy must still show after hold plus two cycles, then ready returns
  task automatic busy_then_ready(input int hold);
    repeat (hold + 2) @(negedge clock_i);
    check_flag(ready, 1'b0);
    wait_ready();
  endtask

  // Read answers are matched against the oldest note
  always @(negedge clock_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        check_word(rdata, exp_q.pop_front());
      end else begin
        // A read answer that nobody asked for always counts as a mismatch
        samples_checked++;
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, rdata, 16'h0000);
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h0e99a333));
    nrst_i = 1'b0;
    irq_i = 1'b0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    check_flag(ready, 1'b1);
    check_flag(erase_err | prog_err | cmd_en, 1'b0);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    repeat (3) @(negedge clock_i);
    check_flag(ready, 1'b1);
    i_cpu.ctrl(1'b1);
    @(negedge clock_i);
    check_flag(cmd_en, 1'b0);
    i_cpu.enable();
    @(negedge clock_i);
    check_flag(cmd_en, 1'b1);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    rd(ra(), 16'h0000);
    busy_then_ready(100);
    rd(ra(), 16'h0080);
    cmd(ra(), fcs_pkg::CMD_READ_ARRAY);
    rd(9'h040, fcs_pkg::ERASED_WORD);
    word = $urandom;
    i_cpu.program_unit(9'h010, 8'($urandom), word);
    rd(ra(), 16'h0000);
    busy_then_ready(80);
    rd(ra(), 16'h0080);
    cmd(ra(), fcs_pkg::CMD_READ_ARRAY);
    rd(9'h010, word[15:0]);
    rd(9'h012, word[31:16]);
    cmd(ra(), fcs_pkg::CMD_READ_STATUS);
    rd(ra(), 16'h0080);
    i_cpu.program_unit(9'h010, 8'h00, ~word);
    repeat (4) @(negedge clock_i);
    check_flag(prog_err, 1'b1);
    rd(ra(), 16'h0090);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    repeat (3) @(negedge clock_i);
    check_flag(ready, 1'b1);
    cmd(ra(), fcs_pkg::CMD_CLEAR_STATUS);
    rd(ra(), 16'h0080);
    cmd(ra(), fcs_pkg::CMD_BLANK_CHECK);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    busy_then_ready(55);
    rd(ra(), 16'h00a0);
    cmd(ra(), fcs_pkg::CMD_CLEAR_STATUS);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_READ_ARRAY);
    repeat (3) @(negedge clock_i);
    check_flag(ready, 1'b1);
    rd(9'h012, word[31:16]);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, 8'h00);
    @(negedge clock_i);
    check_flag(erase_err & prog_err, 1'b1);
    cmd(ra(), fcs_pkg::CMD_CLEAR_STATUS);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    repeat (5) @(negedge clock_i);
    @(posedge clock_i);
    irq_i <= 1'b1;
    repeat (5) @(negedge clock_i);
    check_flag(cmd_en, 1'b0);
    check_flag(ready, 1'b1);
    @(posedge clock_i);
    irq_i <= 1'b0;
    // Let the released interrupt leave its synchroniser, then restart the erase
    repeat (4) @(negedge clock_i);
    i_cpu.enable();
    @(negedge clock_i);
    check_flag(cmd_en, 1'b1);
    cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    busy_then_ready(100);
    tries = 1;
    while (erase_err === 1'b1 && tries < 3) begin
      cmd(ra(), fcs_pkg::CMD_CLEAR_STATUS);
      cmd(ra(), fcs_pkg::CMD_BLOCK_ERASE);
      cmd(BA0, fcs_pkg::CMD_CONFIRM);
      busy_then_ready(100);
      tries++;
    end
    check_flag(erase_err, 1'b0);
    cmd(ra(), fcs_pkg::CMD_READ_ARRAY);
    rd(9'h010, fcs_pkg::ERASED_WORD);
    i_cpu.standby();
    @(negedge clock_i);
    check_flag(cmd_en, 1'b0);
    cmd(ra(), fcs_pkg::CMD_BLANK_CHECK);
    cmd(BA0, fcs_pkg::CMD_CONFIRM);
    repeat (3) @(negedge clock_i);
    check_flag(ready, 1'b1);
    check_flag(exp_q.size() == 0, 1'b1);
    final_report();
  end
endmodule
